// file: rtl/fsync_adc_regs.svh
// constants for the frame-sync converter port: field positions, widths, timing counts
`ifndef FSYNC_ADC_REGS_SVH
`define FSYNC_ADC_REGS_SVH
// result word layout
`define RESULT_BITS 14
`define FRAME_BITS 24
`define LEAD_ZERO_BITS 8
`define STATUS_BITS 2
// fifo shape
`define FIFO_WIDTH 16
`define FIFO_DEPTH 8
// conversion time in serial clock periods after the frame pulse
`define CONV_SCLK_CYCLES 5'h02
`endif

// file: rtl/fsync_adc_pkg.sv
// types for the frame-sync converter port
package fsync_adc_pkg;
   // interface mode latched at the select falling edge
   typedef enum logic [0:0] {
      MODE_SERIAL = 1'b0,
      MODE_FRAME_SYNC = 1'b1
   } port_mode_t;
   // conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_SHIFT = 2'b10
   } conv_state_t;
endpackage

// file: rtl/sample_fifo.sv
// small synchronous fifo holding converter samples
`timescale 1ns/100ps
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and control
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // write side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // read side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   // ===========================================
   // storage
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;
   logic ready_reg, ready_next; // not-full flag, registered so the port sees a flop

   assign in_ready_o = ready_reg;
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem[rd_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // pointer and count update
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
         rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
      // full follows the new count, so ready drops on the edge that fills the last slot
      ready_next = (cnt_next != (AW+1)'(DEPTH));
   end

   // registers; the array is written only on accepted pushes
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b1;
      end else if (clk_en_i) begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
         if (push) begin
            mem[wr_reg] <= in_data_i;
         end
      end
   end
endmodule

// file: rtl/fsync_adc_port.sv
// frame-synchronised serial port of a multichannel converter, device side
`timescale 1ns/100ps
`include "fsync_adc_regs.svh"

// Behaviour
// - frame-sync mode runs only from serial clock
// - frame-sync pin sampled at select fall
// - low sample enters frame-sync mode
// - mode held while select stays low
// - incoming frame pulse starts a conversion
// - outgoing pulse when top bit appears
// - scan configuration ignored in this mode
// - data output changes on clock falls
// - zeros byte, top bits, low bits plus status
module fsync_adc_port (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // pins from the processor
   input wire logic sclk_i,
   input wire logic select_n_i,
   input wire logic frame_sync_in_i,
   // pins to the processor
   output logic sdata_o,
   output logic frame_sync_out_o,
   // converter core side: sample stream in
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic [`RESULT_BITS-1:0] sample_i,
   input wire logic [`STATUS_BITS-1:0] sample_status_i,
   // scan request from the channel logic
   input wire logic scan_enable_i,
   // status
   output logic frame_mode_o,
   output logic scan_active_o
);
   // ===========================================
   // pin synchronisers (two flops, first read only by second)
   logic [1:0] sclk_sync, sel_sync, fsi_sync;
   logic sclk_d, sel_d;
   logic sclk_rise, sclk_fall, sel_fall;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sclk_sync <= 2'h0;
         sel_sync <= 2'h3;
         fsi_sync <= 2'h3;
         sclk_d <= 1'b0;
         sel_d <= 1'b1;
      end else if (clk_en_i) begin
         sclk_sync <= {sclk_sync[0], sclk_i};
         sel_sync <= {sel_sync[0], select_n_i};
         fsi_sync <= {fsi_sync[0], frame_sync_in_i};
         sclk_d <= sclk_sync[1];
         sel_d <= sel_sync[1];
      end
   end

   // edges of the processor clock and select, from the settled copies
   assign sclk_rise = sclk_sync[1] && !sclk_d;
   assign sclk_fall = !sclk_sync[1] && sclk_d;
   assign sel_fall = !sel_sync[1] && sel_d;

   // ===========================================
   // sample buffer between the converter core and the shifter
   logic fifo_valid, fifo_pop;
   logic [`FIFO_WIDTH-1:0] fifo_data;

   sample_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .in_data_i({sample_i, sample_status_i}),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   // ===========================================
   // mode, sequencer and shifter
   fsync_adc_pkg::port_mode_t mode_reg, mode_next;
   fsync_adc_pkg::conv_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;            // bit or wait counter
   logic [`FRAME_BITS-1:0] shift_reg, shift_next;
   logic sdata_reg, sdata_next;
   logic fso_reg, fso_next;
   logic scan_reg, scan_next;

   // next-state logic for the whole port
   always_comb begin
      mode_next = mode_reg;
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      sdata_next = sdata_reg;
      fso_next = fso_reg;
      fifo_pop = 1'b0;
      // mode picked from the frame-sync level at each select fall; the
      // clock is always the processor's, no internal oscillator path exists
      if (sel_fall) begin
         mode_next = fsi_sync[1] ? fsync_adc_pkg::MODE_SERIAL
                                 : fsync_adc_pkg::MODE_FRAME_SYNC;
      end
      // releasing select leaves frame-sync mode; low select keeps it
      if (sel_sync[1]) begin
         mode_next = fsync_adc_pkg::MODE_SERIAL;
      end
      // pulse ends one processor clock period after it rose
      if (sclk_fall && fso_reg) begin
         fso_next = 1'b0;
      end
      unique case (state_reg)
         fsync_adc_pkg::ST_IDLE: begin
            // a frame pulse on a rising clock edge starts one conversion
            if (mode_reg == fsync_adc_pkg::MODE_FRAME_SYNC && !sel_sync[1] &&
                sclk_rise && fsi_sync[1]) begin
               state_next = fsync_adc_pkg::ST_CONVERT;
               cnt_next = `CONV_SCLK_CYCLES;
            end
         end
         fsync_adc_pkg::ST_CONVERT: begin
            // wait a few clock falls, then launch the first (zero) bit
            if (sclk_fall) begin
               if (cnt_reg != 5'h00) begin
                  cnt_next = cnt_reg - 5'h01;
               end else if (fifo_valid) begin
                  fifo_pop = 1'b1;
                  // zeros byte, then result, then two status bits
                  shift_next = {{`LEAD_ZERO_BITS{1'b0}}, fifo_data};
                  sdata_next = 1'b0;
                  cnt_next = 5'(`FRAME_BITS - 1);
                  state_next = fsync_adc_pkg::ST_SHIFT;
               end
            end
         end
         fsync_adc_pkg::ST_SHIFT: begin
            if (sclk_fall) begin
               shift_next = {shift_reg[`FRAME_BITS-2:0], 1'b0};
               sdata_next = shift_reg[`FRAME_BITS-2];
               // msb leaves on the fall that starts bit 8
               fso_next = (cnt_reg == 5'(`FRAME_BITS - `LEAD_ZERO_BITS));
               cnt_next = cnt_reg - 5'h01;
               if (cnt_reg == 5'h00) begin
                  sdata_next = 1'b0;
                  fso_next = 1'b0;
                  state_next = fsync_adc_pkg::ST_IDLE;
               end
            end
         end
         default: state_next = fsync_adc_pkg::ST_IDLE;
      endcase
      // scanning only outside frame-sync mode
      scan_next = scan_enable_i && (mode_reg == fsync_adc_pkg::MODE_SERIAL);
   end

   // registers for the port
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_reg <= fsync_adc_pkg::MODE_SERIAL;
         state_reg <= fsync_adc_pkg::ST_IDLE;
         cnt_reg <= 5'h00;
         shift_reg <= '0;
         sdata_reg <= 1'b0;
         fso_reg <= 1'b0;
         scan_reg <= 1'b0;
      end else if (clk_en_i) begin
         mode_reg <= mode_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         sdata_reg <= sdata_next;
         fso_reg <= fso_next;
         scan_reg <= scan_next;
      end
   end

   assign sdata_o = sdata_reg;
   assign frame_sync_out_o = fso_reg;
   assign frame_mode_o = mode_reg;
   assign scan_active_o = scan_reg;

   // ===========================================
   // checks
   a_mode_low_fs: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && sel_fall && !fsi_sync[1] |=> frame_mode_o)
      else $error("frame-sync mode not entered on low sample");
   a_mode_high_fs: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && sel_fall && fsi_sync[1] |=> !frame_mode_o)
      else $error("serial mode not kept on high sample");
   a_mode_held: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && frame_mode_o && !sel_sync[1] && !sel_fall |=> frame_mode_o)
      else $error("mode lost while select low");
   a_scan_off: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && frame_mode_o |=> !scan_active_o)
      else $error("scan active in frame-sync mode");
   a_data_falls: assert property (@(posedge clk_i) disable iff (reset_i)
      $changed(sdata_o) |-> $past(sclk_fall))
      else $error("data changed away from clock fall");
   a_fso_align: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(frame_sync_out_o) |-> $past(sclk_fall))
      else $error("outgoing pulse not launched on a clock fall");
   a_fso_width: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && frame_sync_out_o && !sclk_fall |=> frame_sync_out_o)
      else $error("outgoing pulse shorter than one clock period");
   a_fso_end: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && frame_sync_out_o && sclk_fall |=> !frame_sync_out_o)
      else $error("outgoing pulse longer than one clock period");
   a_start_conv: assert property (@(posedge clk_i) disable iff (reset_i)
      clk_en_i && state_reg == fsync_adc_pkg::ST_IDLE && frame_mode_o && !sel_sync[1] &&
      sclk_rise && fsi_sync[1] |=> state_reg == fsync_adc_pkg::ST_CONVERT)
      else $error("frame pulse did not start a conversion");
   a_fso_idle: assert property (@(posedge clk_i) disable iff (reset_i)
      state_reg != fsync_adc_pkg::ST_SHIFT |-> ##1 !$rose(frame_sync_out_o))
      else $error("outgoing pulse outside data phase");
endmodule

// file: testbench/dsp_port_model.sv
// processor-side serial port model: select, frame pulses, serial clock, capture
`timescale 1ns/100ps
module dsp_port_model (
   // pacing clock
   input wire logic clk_i,
   // pins toward the converter
   output logic sclk_o,
   output logic select_n_o,
   output logic frame_sync_o,
   // pins from the converter
   input wire logic sdata_i,
   input wire logic frame_sync_out_i
);
   // =====
   // pacing
   // half serial period is four system clocks, so both sides share one source
   task automatic half();
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   // idle: clock parked low, deselected, frame pin low
   initial begin
      sclk_o = 1'b0;
      select_n_o = 1'b1;
      frame_sync_o = 1'b0;
   end
   // =====
   // select handling
   // falling select wakes the converter; the frame pin level picks the mode
   task automatic select_drop(input logic level);
      frame_sync_o = level;
      half();
      select_n_o = 1'b0;
      half();
      half();
      frame_sync_o = 1'b0;
      half();
   endtask
   // select high ends the session
   task automatic select_raise();
      select_n_o = 1'b1;
      half();
   endtask
   // =====
   // one frame: pulse over the first rise, then 28 periods; clock idles after
   task automatic frame(output logic [23:0] at_rise, output logic [23:0] at_fall,
                        output logic [27:0] pulse);
      at_rise = '0;
      at_fall = '0;
      frame_sync_o = 1'b1;
      half();
      for (int i = 0; i < 28; i++) begin
         // capture on the rise, and again late in the high phase
         if (i >= 3 && i <= 26) at_rise[26-i] = sdata_i;
         pulse[i] = frame_sync_out_i;
         sclk_o = 1'b1;
         half();
         if (i >= 3 && i <= 26) at_fall[26-i] = sdata_i;
         sclk_o = 1'b0;
         frame_sync_o = 1'b0;
         half();
      end
   endtask
endmodule

// file: testbench/test_fsync_adc_port.sv
// self-checking bench for the frame-synchronised converter port
`timescale 1ns/100ps
`include "fsync_adc_regs.svh"
`define CHECK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; $display("unexpected at %0t: %s", $time, msg); end end
module test_fsync_adc_port;
   // =====
   // signals
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic sample_valid_i = 1'b0;
   logic [`RESULT_BITS-1:0] sample_i = '0;
   logic [`STATUS_BITS-1:0] sample_status_i = '0;
   logic scan_enable_i = 1'b1;
   logic sclk_i, select_n_i, frame_sync_in_i, sdata_o, frame_sync_out_o;
   logic sample_ready_o, frame_mode_o, scan_active_o;
   int samples_checked = 0;
   int bad_count = 0;
   logic [23:0] exp_q[$];
   // =====
   // clock, design and partner
   always #50 clk_i = ~clk_i;
   fsync_adc_port DUT (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .sclk_i(sclk_i), .select_n_i(select_n_i), .frame_sync_in_i(frame_sync_in_i),
      .sdata_o(sdata_o), .frame_sync_out_o(frame_sync_out_o),
      .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
      .sample_i(sample_i), .sample_status_i(sample_status_i),
      .scan_enable_i(scan_enable_i), .frame_mode_o(frame_mode_o),
      .scan_active_o(scan_active_o));
   dsp_port_model partner (.clk_i(clk_i), .sclk_o(sclk_i), .select_n_o(select_n_i),
      .frame_sync_o(frame_sync_in_i), .sdata_i(sdata_o),
      .frame_sync_out_i(frame_sync_out_o));
   // =====
   // helpers
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic report_and_stop();
      $display("counts: %0d compared, %0d unexpected", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // =====
   // scenarios
   // quiet outputs and serial mode after reset
   task automatic check_reset();
      `CHECK(frame_mode_o, 1'b0, "mode after reset")
      `CHECK(sample_ready_o, 1'b1, "fifo not empty")
      `CHECK(frame_sync_out_o, 1'b0, "pulse after reset")
      $display("done: reset");
   endtask
   // frame pin high at select fall keeps serial mode, scanning allowed
   task automatic check_serial();
      partner.select_drop(1'b1);
      `CHECK(frame_mode_o, 1'b0, "serial mode lost")
      `CHECK(scan_active_o, 1'b1, "scan blocked")
      partner.select_raise();
      $display("done: serial");
   endtask
   // frame pin low at select fall enters frame mode, scanning gated
   task automatic enter_frame();
      partner.select_drop(1'b0);
      `CHECK(frame_mode_o, 1'b1, "frame mode missed")
      `CHECK(scan_active_o, 1'b0, "scan not gated")
      $display("done: enter");
   endtask
   // enable low freezes mode, scan gate and fifo while pins move; a leaked
   // push here would show up later as a short fill count
   task automatic check_freeze();
      clk_en_i = 1'b0;
      sample_valid_i = 1'b1;
      sample_i = 14'h1FFF;
      partner.select_raise();
      step(2);
      `CHECK(frame_mode_o, 1'b1, "mode moved while frozen")
      `CHECK(scan_active_o, 1'b0, "scan moved while frozen")
      `CHECK(sample_ready_o, 1'b1, "fifo moved while frozen")
      sample_valid_i = 1'b0;
      clk_en_i = 1'b1;
      partner.select_drop(1'b0);
      `CHECK(frame_mode_o, 1'b1, "frame mode not re-entered")
      $display("done: freeze");
   endtask
   // push samples until the fifo refuses; no frames run meanwhile
   task automatic fill_fifo();
      int n;
      logic [`RESULT_BITS-1:0] s;
      n = 0;
      for (int i = 0; i < 12 && sample_ready_o === 1'b1; i++) begin
         s = 14'h2C01 ^ 14'(i * 14'h0A53);
         sample_valid_i = 1'b1;
         sample_i = s;
         sample_status_i = 2'(i);
         exp_q.push_back({8'h00, s, 2'(i)});
         step(1);
         n++;
      end
      sample_valid_i = 1'b0;
      `CHECK(n, `FIFO_DEPTH, "fifo depth")
      `CHECK(sample_ready_o, 1'b0, "full fifo ready")
      $display("done: fill");
   endtask
   // one frame per pulse, select held low throughout, until fifo empty
   task automatic drain_fifo();
      logic [23:0] r, f, e;
      logic [27:0] p;
      for (int i = 0; i < `FIFO_DEPTH; i++) begin
         partner.frame(r, f, p);
         e = exp_q.pop_front();
         `CHECK(r, e, "frame word")
         `CHECK(f, e, "data moved in high phase")
         `CHECK(p, 28'h0000800, "outgoing pulse")
         `CHECK(sdata_o, 1'b0, "data after frame")
         `CHECK(frame_mode_o, 1'b1, "mode dropped")
      end
      `CHECK(sample_ready_o, 1'b1, "fifo not drained")
      $display("done: drain");
   endtask
   // select high leaves frame mode and frees scanning
   task automatic leave_frame();
      partner.select_raise();
      `CHECK(frame_mode_o, 1'b0, "mode kept")
      `CHECK(scan_active_o, 1'b1, "scan still gated")
      $display("done: leave");
   endtask
   // =====
   // main sequence and hang guard
   initial begin
      step(5);
      reset_i = 1'b0;
      step(3);
      check_reset();
      check_serial();
      enter_frame();
      check_freeze();
      fill_fifo();
      drain_fifo();
      leave_frame();
      report_and_stop();
   end
   initial begin
      #5000000;
      bad_count++;
      report_and_stop();
   end
endmodule
